// ==== core/ppfm_top.v ====
/*
  pin function multiplexer for port f (16 bits) and port g (bits 0..13),
  with reset, hold-off and hibernate pin states, the wake indication and
  the crystal drive.
  assumes all control and function drives are on ref_clk; pad inputs and
  oscillator_input are asynchronous and are synchronised here.
*/
// How it works
// - pads float during reset and a hold-off time after it
// - wake indication is driven high during reset and during the hold-off outside hibernate
// - in hibernate every pad floats except wake and crystal outputs
// - in hibernate the wake indication is driven low
// - in hibernate the crystal output rests at one steady level
// - input buffers stay off until software enables them, pulled pins excepted
// - pins start as gpio and change only by software selection
// - port f bit 0: gpio, sport0 tx clock, uart0 rx, timer 6, count up
// - port f bit 1: gpio, sport0 rx clock, uart0 tx, timer 5, count down
// - port f bits 2..5: pwm0 b/c high/low and parallel data 8..11
// - port f bits 6,7: uart1, motor_in_a/b, parallel data 12,13, capture 3
// - port f bits 10..12: spi0 clock/miso/mosi, parallel data 5..3, timer 2
// - port f bit 13: spi0 select 1 out, timer 3, parallel data 2, select in
// - port g bit 0: spi1 select 3, timer clock, parallel clock, uart1 rx, capture 4
// - port g bits 1,2: can rx/tx, spi1 selects 2,1, frame sync 3, timer 4
// - port g bit 3: host wait, spi1 clock, sport1 secondary tx, uart1 tx
// - port g bits 6,7: converter selections, card data 3,2, pwm1 a high/low
// - port g bits 8..11: card data 1,0, command, clock, pwm1 b/c, sport1 rx
`timescale 1ns/1ps
`include "ppfm_consts.vh"
module ppfm_top (
  input  wire          ref_clk,
  input  wire          resetn,
  input  wire          hibernate,
  input  wire          oscillator_input,
  input  wire          wake_request,
  input  wire [89:0]   func_sel,
  input  wire [29:0]   ibuf_enable,
  input  wire [29:0]   gpio_out,
  input  wire [29:0]   gpio_oe,
  input  wire [149:0]  alt_out,
  input  wire [149:0]  alt_oe,
  input  wire [29:0]   pad_in,
  output wire [29:0]   pad_out,
  output wire [29:0]   pad_oe,
  output wire [179:0]  periph_in,
  output wire [29:0]   sel_valid,
  output reg  [89:0]   sel_applied_r,
  output reg           pins_released_r,
  output reg           wake_indication_out,
  output reg           crystal_drive_out
);
  reg  [`PPFM_HOLD_W-1:0] hold_cnt_r;
  reg  [29:0]             ibuf_en_r;
  wire                    pads_on;
  wire                    osc_q;

  // number of alternates each pin offers; slot n is the nth listed below
  function [2:0] ppfm_alt_cnt;
    input integer pin;
    begin
      case (pin)
        0: begin // port f bit 0
          // 1 sport0 tx clock
          // 2 uart0 rx
          // 3 timer 6
          // 4 count up dir 0
          ppfm_alt_cnt = 3'd4;
        end
        1: begin // port f bit 1
          // 1 sport0 rx clock
          // 2 uart0 tx
          // 3 timer 5
          // 4 count down dir 0
          ppfm_alt_cnt = 3'd4;
        end
        2: begin // port f bit 2
          // 1 sport0 tx data
          // 2 pwm0 b high
          // 3 parallel data 8
          // 4 zero marker 0
          ppfm_alt_cnt = 3'd4;
        end
        3: begin // port f bit 3
          // 1 sport0 tx frame sync
          // 2 pwm0 b low
          // 3 parallel data 9
          // 4 count down dir 0
          ppfm_alt_cnt = 3'd4;
        end
        4: begin // port f bit 4
          // 1 sport0 rx frame sync
          // 2 pwm0 c high
          // 3 parallel data 10
          // 4 alt timer clock 0
          ppfm_alt_cnt = 3'd4;
        end
        5: begin // port f bit 5
          // 1 sport0 rx data
          // 2 pwm0 c low
          // 3 parallel data 11
          // 4 alt timer clock 1
          ppfm_alt_cnt = 3'd4;
        end
        6: begin // port f bit 6
          // 1 uart1 tx
          // 2 motor_in_a
          // 3 parallel data 12
          ppfm_alt_cnt = 3'd3;
        end
        7: begin // port f bit 7
          // 1 uart1 rx
          // 2 motor_b
          // 3 parallel data 13
          // 4 capture in 3
          ppfm_alt_cnt = 3'd4;
        end
        8: begin // port f bit 8
          // 1 uart1 rts
          // 2 sport0 tx secondary data
          // 3 parallel data 7
          ppfm_alt_cnt = 3'd3;
        end
        9: begin // port f bit 9
          // 1 uart1 cts
          // 2 sport0 rx secondary data
          // 3 parallel data 6
          // 4 zero marker 0
          ppfm_alt_cnt = 3'd4;
        end
        10: begin // port f bit 10
          // 1 spi0 clock
          // 2 timer 2
          // 3 parallel data 5
          ppfm_alt_cnt = 3'd3;
        end
        11: begin // port f bit 11
          // 1 spi0 miso
          // 2 motor_in_a
          // 3 parallel data 4
          // 4 alt timer clock 2
          ppfm_alt_cnt = 3'd4;
        end
        12: begin // port f bit 12
          // 1 spi0 mosi
          // 2 motor_b
          // 3 parallel data 3
          ppfm_alt_cnt = 3'd3;
        end
        13: begin // port f bit 13
          // 1 spi0 select 1 out
          // 2 timer 3
          // 3 parallel data 2
          // 4 spi0 select in, slave operation
          ppfm_alt_cnt = 3'd4;
        end
        14: begin // port f bit 14
          // 1 spi0 select 2
          // 2 pwm0 a high
          // 3 parallel data 1
          ppfm_alt_cnt = 3'd3;
        end
        15: begin // port f bit 15
          // 1 spi0 select 3
          // 2 pwm0 a low
          // 3 parallel data 0
          ppfm_alt_cnt = 3'd3;
        end
        16: begin // port g bit 0
          // 1 spi1 select 3
          // 2 external timer clock
          // 3 parallel clock
          // 4 uart1 rx
          // 5 capture in 4
          ppfm_alt_cnt = 3'd5;
        end
        17: begin // port g bit 1
          // 1 spi1 select 2
          // 2 parallel frame sync 3
          // 3 can rx
          // 4 capture in 5
          ppfm_alt_cnt = 3'd4;
        end
        18: begin // port g bit 2
          // 1 spi1 select 1
          // 2 timer 4
          // 3 can tx
          // 4 spi1 select in
          ppfm_alt_cnt = 3'd4;
        end
        19: begin // port g bit 3
          // 1 host wait
          // 2 spi1 clock
          // 3 sport1 tx secondary data
          // 4 uart1 tx
          ppfm_alt_cnt = 3'd4;
        end
        20: begin // port g bit 4
          // 1 spi1 mosi
          // 2 sport1 rx secondary data
          // 3 pwm1 sync
          // 4 alt timer clock 6
          ppfm_alt_cnt = 3'd4;
        end
        21: begin // port g bit 5
          // 1 spi1 miso
          // 2 timer 7
          // 3 pwm1 trip
          ppfm_alt_cnt = 3'd3;
        end
        22: begin // port g bit 6
          // 1 converter single/diff select
          // 2 card data 3
          // 3 pwm1 a high
          ppfm_alt_cnt = 3'd3;
        end
        23: begin // port g bit 7
          // 1 converter range select
          // 2 card data 2
          // 3 pwm1 a low
          ppfm_alt_cnt = 3'd3;
        end
        24: begin // port g bit 8
          // 1 sport1 rx secondary data
          // 2 card data 1
          // 3 pwm1 b high
          ppfm_alt_cnt = 3'd3;
        end
        25: begin // port g bit 9
          // 1 sport1 rx data
          // 2 card data 0
          // 3 pwm1 b low
          ppfm_alt_cnt = 3'd3;
        end
        26: begin // port g bit 10
          // 1 sport1 rx frame sync
          // 2 card command
          // 3 pwm1 c high
          // 4 capture in 6
          ppfm_alt_cnt = 3'd4;
        end
        27: begin // port g bit 11
          // 1 sport1 rx clock
          // 2 card clock
          // 3 pwm1 c low
          // 4 alt timer clock 7
          ppfm_alt_cnt = 3'd4;
        end
        28: begin // port g bit 12
          // 1 uart0 rx
          // 2 card data 4
          // 3 parallel data 15
          // 4 capture in 2
          ppfm_alt_cnt = 3'd4;
        end
        29: begin // port g bit 13
          // 1 uart0 tx
          // 2 card data 5
          // 3 parallel data 14
          // 4 zero marker 1
          ppfm_alt_cnt = 3'd4;
        end
        default: ppfm_alt_cnt = 3'd0;
      endcase
    end
  endfunction

  // hold-off counter: pads stay off for a fixed time after reset release
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt_r      <= {`PPFM_HOLD_W{1'b0}};
      pins_released_r <= 1'b0;
    end else if (!pins_released_r) begin
      if (hold_cnt_r == `PPFM_HOLD_CYC - 1) begin
        pins_released_r <= 1'b1;
      end else begin
        hold_cnt_r <= hold_cnt_r + 1'b1;
      end
    end
  end

  // hibernate gates pads at once; no handshake is waited for
  assign pads_on = pins_released_r & ~hibernate;

  // selections load only after hold-off, so every pin wakes as gpio
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_applied_r <= {`PPFM_NPINS{`PPFM_SEL_GPIO}};
    end else if (pins_released_r) begin
      sel_applied_r <= func_sel;
    end
  end

  // input buffers: off from reset unless the pin carries a pull
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ibuf_en_r <= `PPFM_PULL_MASK;
    end else if (pins_released_r) begin
      ibuf_en_r <= ibuf_enable | `PPFM_PULL_MASK;
    end
  end

  // wake indication: high through reset and through hold-off outside hibernate, low in hibernate
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wake_indication_out <= `PPFM_WAKE_RST;
    end else if (hibernate) begin
      wake_indication_out <= 1'b0;
    end else if (!pins_released_r) begin
      wake_indication_out <= 1'b1;
    end else begin
      wake_indication_out <= wake_request;
    end
  end

  ppfm_sync3 u_osc_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       (oscillator_input),
    .q_r     (osc_q)
  );

  // crystal drive is the inverted oscillator level outside reset and hibernate, including in
  // hold-off; it can only follow slow levels since it is sampled here
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      crystal_drive_out <= `PPFM_CRYSTAL_DRIVE_OUT_RST;
    end else if (hibernate) begin
      crystal_drive_out <= `PPFM_CRYSTAL_DRIVE_OUT_HIB;
    end else begin
      crystal_drive_out <= ~osc_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `PPFM_NPINS; i = i + 1) begin : g_pin
      ppfm_pin_cell #(
        .NALT (ppfm_alt_cnt(i))
      ) u_cell (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .pads_on   (pads_on),
        .ibuf_en   (ibuf_en_r[i]),
        .sel       (sel_applied_r[3*i +: 3]),
        .gpio_out  (gpio_out[i]),
        .gpio_oe   (gpio_oe[i]),
        .alt_out   (alt_out[5*i +: 5]),
        .alt_oe    (alt_oe[5*i +: 5]),
        .pad_in    (pad_in[i]),
        .pad_out_r (pad_out[i]),
        .pad_oe_r  (pad_oe[i]),
        .slot_in_r (periph_in[6*i +: 6]),
        .sel_ok_r  (sel_valid[i])
      );
    end
  endgenerate
endmodule // ppfm_top

// ==== shared/ppfm_consts.vh ====
/*
  constants for the port f/g pin function multiplexer.
  assumes inclusion by bare name from every design file that needs it.
*/
`ifndef PPFM_CONSTS_VH
`define PPFM_CONSTS_VH

// pins 0..15 are port f bits 0..15, pins 16..29 are port g bits 0..13
`define PPFM_NPINS     30
`define PPFM_NF        16
`define PPFM_SEL_W     3
`define PPFM_NSLOT     6
`define PPFM_NALT      5
`define PPFM_SEL_GPIO  3'h0

// hold-off after reset release, in ns, and the clock period in ns
`define PPFM_HOLD_NS   2000
`define PPFM_CLK_NS    8
`define PPFM_HOLD_CYC  ((`PPFM_HOLD_NS + `PPFM_CLK_NS - 1) / `PPFM_CLK_NS)
`define PPFM_HOLD_W    8

`define PPFM_WAKE_RST  1'b1
`define PPFM_CRYSTAL_DRIVE_OUT_RST  1'b0
`define PPFM_CRYSTAL_DRIVE_OUT_HIB  1'b0
// pins with pulls keep their input buffers on from reset
`define PPFM_PULL_MASK 30'h00000000

`endif

// ==== core/ppfm_sync3.v ====
/*
  three-flop input synchroniser with agreement filter.
  assumes d comes from outside the ref_clk domain.
*/
`timescale 1ns/1ps
module ppfm_sync3 (
  input  wire ref_clk,
  input  wire resetn,
  input  wire d,
  output reg  q_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // s1_r feeds s2_r only; a change counts once s2 and s3 agree
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r  <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end
endmodule // ppfm_sync3

// ==== core/ppfm_pin_cell.v ====
/*
  one multiplexed pin: picks gpio or one alternate function, registers
  the pad drive and routes the synchronised pad level to the chosen slot.
  assumes sel, enables and function drives come from ref_clk logic.
*/
`timescale 1ns/1ps
`include "ppfm_consts.vh"
module ppfm_pin_cell #(
  parameter [2:0] NALT = 3'd4
) (
  input  wire                  ref_clk,
  input  wire                  resetn,
  input  wire                  pads_on,
  input  wire                  ibuf_en,
  input  wire [2:0]            sel,
  input  wire                  gpio_out,
  input  wire                  gpio_oe,
  input  wire [4:0]            alt_out,
  input  wire [4:0]            alt_oe,
  input  wire                  pad_in,
  output reg                   pad_out_r,
  output reg                   pad_oe_r,
  output reg  [5:0]            slot_in_r,
  output reg                   sel_ok_r
);
  wire       pad_q;
  wire       legal;
  wire [2:0] eff;
  wire [2:0] idx;
  reg        out_sel;
  reg        oe_sel;
  reg  [5:0] slot_in_nxt;
  integer    s;

  ppfm_sync3 u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       (pad_in),
    .q_r     (pad_q)
  );

  // an unoffered code falls back to gpio rather than a dead function
  assign legal = (sel <= NALT);
  assign eff   = legal ? sel : `PPFM_SEL_GPIO;
  assign idx   = eff - 3'd1;

  always @* begin
    if (eff == `PPFM_SEL_GPIO) begin
      out_sel = gpio_out;
      oe_sel  = gpio_oe;
    end else begin
      out_sel = alt_out[idx];
      oe_sel  = alt_oe[idx];
    end
    slot_in_nxt = 6'h00;
    for (s = 0; s < `PPFM_NSLOT; s = s + 1) begin
      slot_in_nxt[s] = ibuf_en & pad_q & (eff == s);
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pad_out_r <= 1'b0;
      pad_oe_r  <= 1'b0;
      slot_in_r <= 6'h00;
      sel_ok_r  <= 1'b1;
    end else begin
      pad_oe_r  <= pads_on & oe_sel;
      pad_out_r <= pads_on ? out_sel : 1'b0;
      slot_in_r <= slot_in_nxt;
      sel_ok_r  <= legal;
    end
  end
endmodule // ppfm_pin_cell

// ==== bench/ppfm_top_props.sv ====
/*
  concurrent checks on the pin function multiplexer top ports.
  assumes one ref_clk domain and the asynchronous active-low resetn.
*/
`timescale 1ns/1ps
module ppfm_top_props (
  input wire logic         ref_clk,
  input wire logic         resetn,
  input wire logic         hibernate,
  input wire logic [89:0]  func_sel,
  input wire logic [29:0]  ibuf_enable,
  input wire logic [29:0]  gpio_out,
  input wire logic [29:0]  gpio_oe,
  input wire logic [29:0]  pad_out,
  input wire logic [29:0]  pad_oe,
  input wire logic [179:0] periph_in,
  input wire logic [29:0]  sel_valid,
  input wire logic [89:0]  sel_applied_r,
  input wire logic         pins_released_r,
  input wire logic         wake_indication_out,
  input wire logic         crystal_drive_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // pin 0 stays on gpio long enough for the two-stage drive path
  sequence gpio_steady_s;
    (pins_released_r && !hibernate && func_sel[2:0] == 3'h0)[*3];
  endsequence
  sequence ibuf_off_s;
    (!ibuf_enable[0])[*6];
  endsequence
  hold_float_a: assert property (!pins_released_r |-> pad_oe == 30'h0)
    else $error("pad driven before hold-off ends");
  wake_hold_a: assert property (!pins_released_r |-> wake_indication_out)
    else $error("wake low before hold-off ends");
  hib_float_a: assert property (hibernate |=> pad_oe == 30'h0)
    else $error("pad driven in hibernate");
  hib_wake_a: assert property (pins_released_r && hibernate |=> !wake_indication_out)
    else $error("wake not low in hibernate");
  hib_crystal_drive_out_a: assert property (hibernate[*2] |=>
    crystal_drive_out == 1'b0 && $stable(crystal_drive_out))
    else $error("crystal output moves in hibernate");
  sel_take_a: assert property (pins_released_r && func_sel[2:0] <= 3'h4
    |=> sel_applied_r[2:0] == $past(func_sel[2:0]))
    else $error("selection not applied after one edge");
  sel_bad_a: assert property (pins_released_r && func_sel[2:0] > 3'h4 |-> ##2 !sel_valid[0])
    else $error("illegal selection not flagged");
  gpio_path_a: assert property (gpio_steady_s |-> pad_oe[0] == $past(gpio_oe[0])
    && pad_out[0] == $past(gpio_out[0]))
    else $error("gpio drive not on pad");
  ibuf_off_a: assert property (ibuf_off_s |-> periph_in[5:0] == 6'h0)
    else $error("input passed with buffer off");
endmodule // ppfm_top_props
bind ppfm_top ppfm_top_props u_props (.ref_clk, .resetn, .hibernate,
  .func_sel, .ibuf_enable, .gpio_out, .gpio_oe, .pad_out, .pad_oe,
  .periph_in, .sel_valid, .sel_applied_r, .pins_released_r,
  .wake_indication_out, .crystal_drive_out);

// ==== bench/ppfm_pad_model.sv ====
/*
  package pins: a driven pin reads back its own drive.
  assumes no pulls, so a floating pin shows a level that flips each cycle.
*/
`timescale 1ns/1ps
module ppfm_pad_model (
  input  wire logic        ref_clk,
  input  wire logic [29:0] pad_out,
  input  wire logic [29:0] pad_oe,
  output wire logic [29:0] pad_in
);
  logic [29:0] drift_r;
  initial drift_r = 30'h2aaaaaaa;
  // a stale level would let a missing drive go unseen
  always @(posedge ref_clk) drift_r <= ~drift_r;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drift_r);
endmodule // ppfm_pad_model

// ==== bench/ppfm_top_test.sv ====
/*
  self-checking bench for the pin function multiplexer top.
  assumes ppfm_pad_model closes the pads and the bound checker runs beside.
*/
`timescale 1ns/1ps
`include "ppfm_consts.vh"
module ppfm_top_test;
  reg          ref_clk, resetn, hibernate, oscillator_input, wake_request;
  reg  [89:0]  func_sel;
  reg  [29:0]  ibuf_enable, gpio_out, gpio_oe;
  reg  [149:0] alt_out, alt_oe;
  wire [29:0]  pad_in, pad_out, pad_oe, sel_valid;
  wire [179:0] periph_in;
  wire [89:0]  sel_applied_r;
  wire         pins_released_r, wake_indication_out, crystal_drive_out;
  reg  [31:0]  seed;
  integer      bad_count, checks_done, cyc, r, p, c, e, k;
  reg          exp_oe, exp_out, cx;

  ppfm_top dut (.ref_clk(ref_clk), .resetn(resetn), .hibernate(hibernate),
    .oscillator_input(oscillator_input), .wake_request(wake_request),
    .func_sel(func_sel), .ibuf_enable(ibuf_enable), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .alt_out(alt_out), .alt_oe(alt_oe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .periph_in(periph_in),
    .sel_valid(sel_valid), .sel_applied_r(sel_applied_r),
    .pins_released_r(pins_released_r),
    .wake_indication_out(wake_indication_out),
    .crystal_drive_out(crystal_drive_out));
  ppfm_pad_model pads (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_in(pad_in));

  always #4 ref_clk = ~ref_clk;
  always #13 oscillator_input = ~oscillator_input;

  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function integer alt_cnt(input integer q);
    if (q < 6 || q == 7 || q == 9 || q == 11 || q == 13) alt_cnt = 4;
    else if (q < 16) alt_cnt = 3;
    else if (q == 16) alt_cnt = 5;
    else if (q < 21 || q > 25) alt_cnt = 4;
    else alt_cnt = 3;
  endfunction
  task check(input [31:0] seen, input [31:0] want);
    checks_done = checks_done + 1;
    if (seen !== want) begin
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      bad_count = bad_count + 1;
    end
  endtask
  task wrap_up;
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end

  // reset, hold-off checks, then wait for release under a bound
  task do_reset;
    resetn = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 resetn = 1'b1;
    repeat (100) @(posedge ref_clk);
    #1 check(pad_oe, 0);
    check(wake_indication_out, 1);
    // sample a step after each edge so the release edge is not missed
    for (k = 0; k < 400 && pins_released_r !== 1'b1; k = k + 1) begin
      @(posedge ref_clk);
      #1;
    end
    check(k, `PPFM_HOLD_CYC - 100);
    check(pins_released_r, 1);
    check(|sel_applied_r, 0);
  endtask
  // mode below zero draws codes at random, else every pin gets mode
  task round(input integer mode);
    for (k = 0; k < 150; k = k + 1) begin
      seed = nx(seed);
      alt_out[k] = seed[0];
      alt_oe[k] = seed[5];
    end
    for (k = 0; k < 30; k = k + 1) begin
      seed = nx(seed);
      gpio_out[k] = seed[0];
      gpio_oe[k] = seed[3];
      ibuf_enable[k] = seed[7] | (mode == 0);
      func_sel[3*k +: 3] = (mode < 0) ? seed[10:8] : mode;
      wake_request = seed[12];
    end
    repeat (10) @(posedge ref_clk);
    #1 check(wake_indication_out, wake_request);
    for (p = 0; p < 30; p = p + 1) begin
      c = func_sel[3*p +: 3];
      e = (c <= alt_cnt(p)) ? c : 0;
      exp_oe = (e == 0) ? gpio_oe[p] : alt_oe[5*p+e-1];
      // pad value follows the selected drive even while the pad floats
      exp_out = (e == 0) ? gpio_out[p] : alt_out[5*p+e-1];
      check(pad_oe[p], exp_oe);
      check(pad_out[p], exp_out);
      check(sel_valid[p], c <= alt_cnt(p));
      if (exp_oe) check(periph_in[6*p+e], ibuf_enable[p] & exp_out);
    end
  endtask

  initial begin
    ref_clk = 1'b0; resetn = 1'b0; hibernate = 1'b0; oscillator_input = 1'b0;
    wake_request = 1'b0; func_sel = 90'h0; ibuf_enable = 30'h0;
    gpio_out = 30'h3fffffff; gpio_oe = 30'h3fffffff;
    alt_out = 150'h0; alt_oe = 150'h0;
    seed = 32'h1a; bad_count = 0; checks_done = 0; cyc = 0;
    do_reset;
    repeat (3) @(posedge ref_clk);
    #1 check(pad_oe, 30'h3fffffff);
    round(0);
    round(5);
    round(7);
    for (r = 0; r < 20; r = r + 1) round(-1);
    hibernate = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 check(pad_oe, 0);
    check(wake_indication_out, 0);
    cx = `PPFM_CRYSTAL_DRIVE_OUT_HIB;
    for (k = 0; k < 6; k = k + 1) begin
      @(posedge ref_clk);
      #1 check(crystal_drive_out, cx);
    end
    hibernate = 1'b0;
    round(-1);
    do_reset;
    round(-1);
    wrap_up;
  end
endmodule // ppfm_top_test
